// File: design/cpcr_pkg.sv
// Constants, field layout and reset values of the processor configuration register bank
package cpcr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int CPCR_ADDR_W = 12;
  localparam int CPCR_DATA_W = 64;
  localparam int CPCR_CHUNKS = 4;
  localparam int CPCR_SEL_W = 2;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] CPCR_ADDR_POWERON = 12'h02a;
  localparam logic [11:0] CPCR_ADDR_TEST_CTRL = 12'h033;
  localparam logic [11:0] CPCR_ADDR_UPD_TRIG = 12'h079;
  localparam logic [11:0] CPCR_ADDR_CHUNK0 = 12'h088;
  localparam logic [11:0] CPCR_ADDR_CHUNK1 = 12'h089;
  localparam logic [11:0] CPCR_ADDR_CHUNK2 = 12'h08a;
  localparam logic [11:0] CPCR_ADDR_CHUNK3 = 12'h08b;

  // ==========================================================================
  // Power-on configuration field positions
  localparam int CPCR_PO_BINIT_OBS = 12;
  localparam int CPCR_PO_IOQ_DEPTH = 13;
  localparam int CPCR_PO_VECTOR_LOW = 14;
  localparam int CPCR_PO_FRC_MODE = 15;
  localparam int CPCR_PO_CLUSTER_LO = 16;
  localparam int CPCR_PO_BUS_FREQ_LO = 18;
  localparam int CPCR_PO_ARB_ID_LO = 20;
  localparam int CPCR_PO_RATIO_LO = 22;
  localparam int CPCR_PO_LOW_POWER = 26;
  localparam int CPCR_PO_RATIO_HI = 27;

  // Bus frequency codes
  localparam logic [1:0] CPCR_FREQ_66 = 2'h0;
  localparam logic [1:0] CPCR_FREQ_100 = 2'h2;
  localparam logic [1:0] CPCR_FREQ_133 = 2'h1;
  localparam logic [1:0] CPCR_FREQ_RSVD = 2'h3;

  // ==========================================================================
  // Test-control field positions
  localparam int CPCR_TC_STREAM_DIS = 30;
  localparam int CPCR_TC_LOCK_DIS = 31;

  // Chunk that doubles as update signature holder
  localparam logic [1:0] CPCR_SIG_CHUNK = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic CPCR_RST_LOW_POWER = 1'h0;
  localparam logic CPCR_RST_STREAM_DIS = 1'h0;
  localparam logic CPCR_RST_LOCK_DIS = 1'h0;
  localparam logic [63:0] CPCR_RST_WORD = 64'h0;

endpackage

// File: design/cpcr_chunk_if.sv
// Carrier between register front end and chunk data bank
`timescale 1ns/10ps
interface cpcr_chunk_if import cpcr_pkg::*;;
  logic sw_we;
  logic [CPCR_SEL_W-1:0] sw_sel;
  logic [CPCR_DATA_W-1:0] sw_wdata;
  logic fill_valid;
  logic [CPCR_SEL_W-1:0] fill_sel;
  logic [CPCR_DATA_W-1:0] fill_data;
  logic sig_mode;
  logic [CPCR_CHUNKS-1:0][CPCR_DATA_W-1:0] data;

  modport ctrl (
    output sw_we, sw_sel, sw_wdata, fill_valid, fill_sel, fill_data, sig_mode,
    input data
  );
  modport bank (
    input sw_we, sw_sel, sw_wdata, fill_valid, fill_sel, fill_data, sig_mode,
    output data
  );
endinterface

// File: design/cpcr_chunk_bank.sv
// Four-entry bank of 64-bit cache chunk data words
`timescale 1ns/10ps
module cpcr_chunk_bank import cpcr_pkg::*; (
  input wire logic mclk,   // Core clock
  input wire logic reset_n, // Synchronous reset, active low
  cpcr_chunk_if.bank bus    // Write and fill requests, stored words
);

  logic [CPCR_DATA_W-1:0] chunk_mem [CPCR_CHUNKS];

  // ==========================================================================
  // Storage, one entry per chunk
  genvar i;
  generate
    for (i = 0; i < CPCR_CHUNKS; i++)
    begin : g_chunk
      logic fill_hit;
      logic sw_hit;
      assign fill_hit = bus.fill_valid && (bus.fill_sel == CPCR_SEL_W'(i)) &&
                        !(bus.sig_mode && (CPCR_SEL_W'(i) == CPCR_SIG_CHUNK));
      assign sw_hit = bus.sw_we && (bus.sw_sel == CPCR_SEL_W'(i));

      // Cache return or software write
      // Cache return wins, except a chunk 3 return in signature mode, which is dropped and lets a software write through
      always_ff @(posedge mclk)
      begin
        if (!reset_n)
        begin
          chunk_mem[i] <= CPCR_RST_WORD;
        end
        else if (fill_hit)
        begin
          chunk_mem[i] <= bus.fill_data;
        end
        else if (sw_hit)
        begin
          chunk_mem[i] <= bus.sw_wdata;
        end
      end

      assign bus.data[i] = chunk_mem[i];
    end
  endgenerate

endmodule

// File: design/cpcr_regs.sv
// Processor configuration register bank: power-on fields, test control, chunk data
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module cpcr_regs import cpcr_pkg::*; (
  input wire logic mclk,                          // Core clock, 100 MHz
  input wire logic reset_n,                       // Synchronous reset, active low
  input wire logic [CPCR_ADDR_W-1:0] reg_addr,    // Register address
  input wire logic [CPCR_DATA_W-1:0] reg_wdata,   // Write data
  input wire logic reg_wr,                        // Write strobe
  input wire logic reg_rd,                        // Read strobe
  output logic [CPCR_DATA_W-1:0] reg_rdata,       // Read data, cycle after strobe
  input wire logic strap_binit_observe,           // Strap: BINIT observation
  input wire logic strap_ioq_depth_one,           // Strap: queue depth one
  input wire logic strap_vector_low,              // Strap: vector below 1Mbyte
  input wire logic strap_frc_mode,                // Strap: FRC mode
  input wire logic [1:0] strap_cluster_id,        // Strap: cluster ID
  input wire logic [1:0] strap_bus_freq,          // Strap: bus frequency code
  input wire logic [1:0] strap_arb_id,            // Strap: arbitration ID
  input wire logic [3:0] strap_clock_ratio,       // Strap: clock ratio low bits
  input wire logic strap_clock_ratio_hi,          // Strap: clock ratio top bit
  output logic low_power_en,                      // Low-power mode enable
  output logic streaming_buffer_disable,          // Streaming buffer disable
  input wire logic locked_access,                 // Core requests a locked access
  input wire logic split_access,                  // Locked access is split
  output logic bus_lock,                          // Bus lock output, active high
  output logic update_trigger,                    // Pulse on trigger write
  input wire logic signature_mode,                // Chunk 3 used as signature
  input wire logic cache_fill_valid,              // Cache returns a chunk
  input wire logic [CPCR_SEL_W-1:0] cache_fill_chunk, // Returned chunk number
  input wire logic [CPCR_DATA_W-1:0] cache_fill_data, // Returned chunk data
  output logic [CPCR_CHUNKS-1:0][CPCR_DATA_W-1:0] cache_chunk_data // Chunks to cache
);

  // ==========================================================================
  // Address decode
  logic hit_poweron;
  logic hit_test_ctrl;
  logic hit_upd_trig;
  logic hit_chunk;
  logic [CPCR_SEL_W-1:0] chunk_sel;

  assign hit_poweron = (reg_addr == CPCR_ADDR_POWERON);
  assign hit_test_ctrl = (reg_addr == CPCR_ADDR_TEST_CTRL);
  assign hit_upd_trig = (reg_addr == CPCR_ADDR_UPD_TRIG);
  assign hit_chunk = (reg_addr == CPCR_ADDR_CHUNK0) || (reg_addr == CPCR_ADDR_CHUNK1) ||
                     (reg_addr == CPCR_ADDR_CHUNK2) || (reg_addr == CPCR_ADDR_CHUNK3);
  assign chunk_sel = reg_addr[CPCR_SEL_W-1:0];

  // ==========================================================================
  // Register select
  typedef enum logic [2:0] {
    CPCR_REG_NONE,
    CPCR_REG_POWERON,
    CPCR_REG_TEST_CTRL,
    CPCR_REG_UPD_TRIG,
    CPCR_REG_CHUNK
  } cpcr_reg_sel_t;
  cpcr_reg_sel_t reg_sel;

  // One source per address keeps the read mux a plain case
  always_comb
  begin
    reg_sel = CPCR_REG_NONE;
    if (hit_poweron)
    begin
      reg_sel = CPCR_REG_POWERON;
    end
    else if (hit_test_ctrl)
    begin
      reg_sel = CPCR_REG_TEST_CTRL;
    end
    else if (hit_upd_trig)
    begin
      reg_sel = CPCR_REG_UPD_TRIG;
    end
    else if (hit_chunk)
    begin
      reg_sel = CPCR_REG_CHUNK;
    end
  end

  // ==========================================================================
  // Power-on straps
  // Straps are caught once, at the first edge after reset release, so a
  // strap that moves later never disturbs the reported configuration.
  logic straps_taken;
  logic po_binit_obs;
  logic po_ioq_depth_one;
  logic po_vector_low;
  logic po_frc_mode;
  logic [1:0] po_cluster_id;
  logic [1:0] po_bus_freq;
  logic [1:0] po_arb_id;
  logic [3:0] po_ratio;
  logic po_ratio_hi;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      straps_taken <= 1'h0;
    end
    else
    begin
      straps_taken <= 1'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      po_binit_obs <= 1'h0;
      po_ioq_depth_one <= 1'h0;
      po_vector_low <= 1'h0;
      po_frc_mode <= 1'h0;
      po_cluster_id <= 2'h0;
      po_bus_freq <= CPCR_FREQ_66;
      po_arb_id <= 2'h0;
      po_ratio <= 4'h0;
      po_ratio_hi <= 1'h0;
    end
    else if (!straps_taken)
    begin
      po_binit_obs <= strap_binit_observe;
      po_ioq_depth_one <= strap_ioq_depth_one;
      po_vector_low <= strap_vector_low;
      po_frc_mode <= strap_frc_mode;
      po_cluster_id <= strap_cluster_id;
      po_bus_freq <= strap_bus_freq;
      po_arb_id <= strap_arb_id;
      po_ratio <= strap_clock_ratio;
      po_ratio_hi <= strap_clock_ratio_hi;
    end
  end

  // ==========================================================================
  // Low-power enable
  // Writable low-power bit
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      low_power_en <= CPCR_RST_LOW_POWER;
    end
    else if (reg_wr && hit_poweron)
    begin
      low_power_en <= reg_wdata[CPCR_PO_LOW_POWER];
    end
  end

  // ==========================================================================
  // Test control
  logic lock_split_disable;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      streaming_buffer_disable <= CPCR_RST_STREAM_DIS;
      lock_split_disable <= CPCR_RST_LOCK_DIS;
    end
    else if (reg_wr && hit_test_ctrl)
    begin
      streaming_buffer_disable <= reg_wdata[CPCR_TC_STREAM_DIS];
      lock_split_disable <= reg_wdata[CPCR_TC_LOCK_DIS];
    end
  end

  // ==========================================================================
  // Bus lock
  // Lock suppressed on split access when the split-lock disable bit is set
  // Registered so the pin never glitches while the request settles
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      bus_lock <= 1'h0;
    end
    else
    begin
      bus_lock <= locked_access && !(split_access && lock_split_disable);
    end
  end

  // ==========================================================================
  // Firmware update trigger
  logic [CPCR_DATA_W-1:0] upd_trig_word;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      upd_trig_word <= CPCR_RST_WORD;
      update_trigger <= 1'h0;
    end
    else
    begin
      update_trigger <= reg_wr && hit_upd_trig;
      if (reg_wr && hit_upd_trig)
      begin
        upd_trig_word <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Chunk data bank
  cpcr_chunk_if chunk_bus ();

  // Route writes and fills to bank
  assign chunk_bus.sw_we = reg_wr && hit_chunk;
  assign chunk_bus.sw_sel = chunk_sel;
  assign chunk_bus.sw_wdata = reg_wdata;
  assign chunk_bus.fill_valid = cache_fill_valid;
  assign chunk_bus.fill_sel = cache_fill_chunk;
  assign chunk_bus.fill_data = cache_fill_data;
  assign chunk_bus.sig_mode = signature_mode;

  cpcr_chunk_bank u_bank (
    .mclk(mclk),
    .reset_n(reset_n),
    .bus(chunk_bus.bank)
  );

  assign cache_chunk_data = chunk_bus.data;

  // ==========================================================================
  // Read path
  logic [CPCR_DATA_W-1:0] poweron_word;
  logic [CPCR_DATA_W-1:0] test_ctrl_word;
  logic [CPCR_DATA_W-1:0] next_rdata;

  always_comb
  begin
    poweron_word = CPCR_RST_WORD;
    poweron_word[CPCR_PO_BINIT_OBS] = po_binit_obs;
    poweron_word[CPCR_PO_IOQ_DEPTH] = po_ioq_depth_one;
    poweron_word[CPCR_PO_VECTOR_LOW] = po_vector_low;
    poweron_word[CPCR_PO_FRC_MODE] = po_frc_mode;
    poweron_word[CPCR_PO_CLUSTER_LO +: 2] = po_cluster_id;
    poweron_word[CPCR_PO_BUS_FREQ_LO +: 2] = po_bus_freq;
    poweron_word[CPCR_PO_ARB_ID_LO +: 2] = po_arb_id;
    poweron_word[CPCR_PO_RATIO_LO +: 4] = po_ratio;
    poweron_word[CPCR_PO_LOW_POWER] = low_power_en;
    poweron_word[CPCR_PO_RATIO_HI] = po_ratio_hi;
  end

  always_comb
  begin
    test_ctrl_word = CPCR_RST_WORD;
    test_ctrl_word[CPCR_TC_STREAM_DIS] = streaming_buffer_disable;
    test_ctrl_word[CPCR_TC_LOCK_DIS] = lock_split_disable;
  end

  // Unmapped addresses read zero, so probing software sees no stale data
  always_comb
  begin
    next_rdata = CPCR_RST_WORD;
    if (reg_rd)
    begin
      case (reg_sel)
        CPCR_REG_POWERON:
        begin
          next_rdata = poweron_word;
        end
        CPCR_REG_TEST_CTRL:
        begin
          next_rdata = test_ctrl_word;
        end
        CPCR_REG_UPD_TRIG:
        begin
          next_rdata = upd_trig_word;
        end
        CPCR_REG_CHUNK:
        begin
          next_rdata = chunk_bus.data[chunk_sel];
        end
        default:
        begin
          next_rdata = CPCR_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reg_rdata <= CPCR_RST_WORD;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// File: verification/cpcr_regs_checker.sv
// Port-level assertions for the configuration register bank
`timescale 1ns/10ps
module cpcr_regs_checker import cpcr_pkg::*; (
  input wire logic mclk, // Core clock
  input wire logic reset_n, // Sync reset
  input wire logic [CPCR_ADDR_W-1:0] reg_addr, // Address
  input wire logic [CPCR_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [CPCR_DATA_W-1:0] reg_rdata, // Read data
  input wire logic low_power_en, // Low-power enable
  input wire logic locked_access, // Locked request
  input wire logic split_access, // Split request
  input wire logic bus_lock, // Lock output
  input wire logic signature_mode, // Chunk 3 usage
  input wire logic cache_fill_valid, // Fill strobe
  input wire logic [CPCR_SEL_W-1:0] cache_fill_chunk, // Fill chunk
  input wire logic [CPCR_DATA_W-1:0] cache_fill_data, // Fill data
  input wire logic [CPCR_CHUNKS-1:0][CPCR_DATA_W-1:0] cache_chunk_data // Chunks
);
  logic [63:0] rd_word;
  logic tc_lock_dis;

  // Shadow of the split-lock disable bit, kept from bus writes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tc_lock_dis <= 1'b0;
    end
    else if (reg_wr && reg_addr == CPCR_ADDR_TEST_CTRL)
    begin
      tc_lock_dis <= reg_wdata[CPCR_TC_LOCK_DIS];
    end
  end

  // ==========================================================================
  // Chunk word seen at the read strobe
  always_ff @(posedge mclk)
  begin
    rd_word <= cache_chunk_data[reg_addr[1:0]];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Assertions
  a_po_reserved: assert property ($past(reg_rd) && $past(reg_addr) == CPCR_ADDR_POWERON
    |-> reg_rdata[63:28] == 36'h0 && reg_rdata[11:0] == 12'h0)
    else $error("power-on reserved bits not zero");
  a_tc_reserved: assert property ($past(reg_rd) && $past(reg_addr) == CPCR_ADDR_TEST_CTRL
    |-> reg_rdata[63:32] == 32'h0 && reg_rdata[29:0] == 30'h0)
    else $error("test-control reserved bits not zero");
  a_lowpow_write: assert property (reg_wr && reg_addr == CPCR_ADDR_POWERON
    |=> low_power_en == $past(reg_wdata[CPCR_PO_LOW_POWER]))
    else $error("low-power enable not written");
  a_lock_open: assert property ($past(reset_n) && $past(locked_access)
    && !$past(split_access) |-> bus_lock)
    else $error("unsplit locked access not locked");
  a_lock_split: assert property ($past(reset_n) |-> bus_lock ==
    ($past(locked_access) && !($past(split_access) && $past(tc_lock_dis))))
    else $error("bus lock does not follow split disable");
  a_fill_store: assert property (cache_fill_valid
    && !(signature_mode && cache_fill_chunk == CPCR_SIG_CHUNK)
    |=> cache_chunk_data[$past(cache_fill_chunk)] == $past(cache_fill_data))
    else $error("fill not stored");
  a_sig_hold: assert property (cache_fill_valid && signature_mode
    && cache_fill_chunk == CPCR_SIG_CHUNK && !reg_wr |=> $stable(cache_chunk_data[3]))
    else $error("signature holder overwritten by fill");
  a_chunk_write: assert property (reg_wr && reg_addr[11:2] == 10'h022
    && !(cache_fill_valid && cache_fill_chunk == reg_addr[1:0])
    |=> cache_chunk_data[$past(reg_addr[1:0])] == $past(reg_wdata))
    else $error("chunk write lost");
  a_chunk_read: assert property ($past(reg_rd) && $past(reg_addr[11:2]) == 10'h022
    && !$past(cache_fill_valid) |-> reg_rdata == rd_word)
    else $error("chunk read data wrong");
endmodule

bind cpcr_regs cpcr_regs_checker chk_u (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .low_power_en, .locked_access, .split_access, .bus_lock,
  .signature_mode, .cache_fill_valid, .cache_fill_chunk, .cache_fill_data, .cache_chunk_data);

// File: verification/test_cpcr_regs.sv
// Directed register-access test of the configuration register bank
`timescale 1ns/10ps
module test_cpcr_regs import cpcr_pkg::*;;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic [63:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic strap_binit_observe = 1'b0;
  logic strap_ioq_depth_one = 1'b0;
  logic strap_vector_low = 1'b0;
  logic strap_frc_mode = 1'b0;
  logic [1:0] strap_cluster_id = 2'h0;
  logic [1:0] strap_bus_freq = 2'h0;
  logic [1:0] strap_arb_id = 2'h0;
  logic [3:0] strap_clock_ratio = 4'h0;
  logic strap_clock_ratio_hi = 1'b0;
  logic locked_access = 1'b0;
  logic split_access = 1'b0;
  logic signature_mode = 1'b0;
  logic cache_fill_valid = 1'b0;
  logic [1:0] cache_fill_chunk = 2'h0;
  logic [63:0] cache_fill_data = 64'h0;
  logic low_power_en, streaming_buffer_disable, bus_lock, update_trigger;
  logic [3:0][63:0] cache_chunk_data;
  int n_mismatch = 0;
  int samples_checked = 0;

  cpcr_regs dut_u (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strap_binit_observe, .strap_ioq_depth_one, .strap_vector_low, .strap_frc_mode,
    .strap_cluster_id, .strap_bus_freq, .strap_arb_id, .strap_clock_ratio,
    .strap_clock_ratio_hi, .low_power_en, .streaming_buffer_disable, .locked_access,
    .split_access, .bus_lock, .update_trigger, .signature_mode, .cache_fill_valid,
    .cache_fill_chunk, .cache_fill_data, .cache_chunk_data);

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Access tasks
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask

  task automatic fill(input logic [1:0] c, input logic [63:0] d, input logic s);
    @(posedge mclk);
    cache_fill_valid <= 1'b1;
    cache_fill_chunk <= c;
    cache_fill_data <= d;
    signature_mode <= s;
    @(posedge mclk);
    cache_fill_valid <= 1'b0;
  endtask

  // Straps are only taken once, so each pattern needs its own reset
  task automatic boot(input logic [1:0] i);
    @(posedge mclk);
    reset_n <= 1'b0;
    {strap_binit_observe, strap_ioq_depth_one, strap_vector_low, strap_frc_mode} <= {i, ~i};
    strap_cluster_id <= ~i;
    strap_bus_freq <= i;
    strap_arb_id <= i;
    strap_clock_ratio <= {i, ~i};
    strap_clock_ratio_hi <= i[1];
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  function automatic logic [63:0] po(input logic lp);
    po = 64'h0;
    po[27:12] = {strap_clock_ratio_hi, lp, strap_clock_ratio, strap_arb_id, strap_bus_freq,
      strap_cluster_id, strap_frc_mode, strap_vector_low, strap_ioq_depth_one,
      strap_binit_observe};
  endfunction

  function automatic logic [63:0] dat(input int k);
    dat = 64'h0123_4567_89ab_cdef ^ {16{k[3:0]}};
  endfunction

  // ==========================================================================
  // Test sequence
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      boot(i[1:0]);
      rd(CPCR_ADDR_POWERON, po(1'b0));
    end
    rd(CPCR_ADDR_TEST_CTRL, 64'h0);
    wr(CPCR_ADDR_POWERON, '1);
    rd(CPCR_ADDR_POWERON, po(1'b1));
    chk(low_power_en, 1'b1);
    wr(CPCR_ADDR_POWERON, 64'h0);
    @(negedge mclk);
    chk(low_power_en, 1'b0);
    wr(CPCR_ADDR_TEST_CTRL, '1);
    rd(CPCR_ADDR_TEST_CTRL, 64'hc000_0000);
    chk(streaming_buffer_disable, 1'b1);
    for (int j = 0; j < 8; j++)
    begin
      if (j == 4)
        wr(CPCR_ADDR_TEST_CTRL, 64'h0);
      @(posedge mclk);
      locked_access <= j[0];
      split_access <= j[1];
      @(posedge mclk);
      @(negedge mclk);
      chk(bus_lock, j[0] && !(j[1] && j < 4));
    end
    wr(CPCR_ADDR_UPD_TRIG, dat(7));
    @(negedge mclk);
    chk(update_trigger, 1'b1);
    @(negedge mclk);
    chk(update_trigger, 1'b0);
    rd(CPCR_ADDR_UPD_TRIG, dat(7));
    for (int k = 0; k < 4; k++)
      wr(CPCR_ADDR_CHUNK0 + 12'(k), dat(k));
    for (int k = 0; k < 4; k++)
    begin
      rd(CPCR_ADDR_CHUNK0 + 12'(k), dat(k));
      chk(cache_chunk_data[k], dat(k));
    end
    fill(2'h2, dat(9), 1'b0);
    rd(CPCR_ADDR_CHUNK2, dat(9));
    fill(2'h3, dat(10), 1'b1);
    rd(CPCR_ADDR_CHUNK3, dat(3));
    fill(2'h3, dat(10), 1'b0);
    rd(CPCR_ADDR_CHUNK3, dat(10));
    // Fill and software write to one chunk in one cycle: fill wins
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= CPCR_ADDR_CHUNK1;
    reg_wdata <= dat(5);
    cache_fill_valid <= 1'b1;
    cache_fill_chunk <= 2'h1;
    cache_fill_data <= dat(6);
    @(posedge mclk);
    reg_wr <= 1'b0;
    cache_fill_valid <= 1'b0;
    rd(CPCR_ADDR_CHUNK1, dat(6));
    wr(12'h100, '1);
    rd(12'h100, 64'h0);
    rd(CPCR_ADDR_CHUNK0, dat(0));
    test_done;
  end

  initial
  begin
    #20000;
    n_mismatch++;
    test_done;
  end
endmodule
